//--- common/fict_consts.svh
// constants for the fifo, checksum, event and timer core
`ifndef FICT_CONSTS_SVH
`define FICT_CONSTS_SVH

// ----------------------------------------
// fifo geometry
// ----------------------------------------
`define FICT_FIFO_DEPTH      64
`define FICT_FIFO_AW         6
`define FICT_LEVEL_W         7

// ----------------------------------------
// checksum seeds and polynomial
// ----------------------------------------
`define FICT_SEED_0          16'h0000
`define FICT_SEED_1          16'h6363
`define FICT_SEED_2          16'hA671
`define FICT_SEED_3          16'hFFFF
`define FICT_CRC_POLY        16'h1021
`define FICT_CRC_RPOLY       16'h8408

// ----------------------------------------
// event flag bit positions
// ----------------------------------------
`define FICT_EV_TIMER        0
`define FICT_EV_ERROR        1
`define FICT_EV_NEAR_EMPTY   2
`define FICT_EV_NEAR_FULL    3
`define FICT_EV_IDLE         4
`define FICT_EV_RX           5
`define FICT_EV_TX           6
`define FICT_EV_CRC          7
`define FICT_EV_W            8

// ----------------------------------------
// timer clock
// ----------------------------------------
`define FICT_TIMER_CLK_KHZ   13560

`endif

//--- common/fict_pkg.sv
// types shared by the core and its helpers
package fict_pkg;

  typedef logic [7:0] fict_byte_t;

  typedef struct packed {
    logic       valid;
    fict_byte_t data;
  } fict_beat_s;

  typedef enum logic [1:0] {
    FICT_CRC_IDLE = 2'b00,
    FICT_CRC_LOAD = 2'b01,
    FICT_CRC_CALC = 2'b10
  } fict_crc_state_e;

endpackage : fict_pkg

//--- verilog/fict_mem.sv
// fifo storage: 64 x 8, registered read data
`timescale 1ns/1ns
module fict_mem
  import fict_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          sys_clk,
  input  wire logic          clk_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire fict_byte_t    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output fict_byte_t         rd_data
);

  fict_byte_t mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : fict_mem

//--- verilog/fict_skid.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ns
module fict_skid
  import fict_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire fict_beat_s in_beat,
  output logic            in_ready,
  output fict_beat_s      out_beat,
  input  wire logic       out_ready
);

  fict_beat_s e0_q;
  fict_beat_s e1_q;

  assign in_ready = !e1_q.valid;
  assign out_beat = e0_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      e0_q <= '0;
      e1_q <= '0;
    end else if (clk_en) begin
      if (!e0_q.valid || out_ready) begin
        if (e1_q.valid) begin
          e0_q <= e1_q;
          e1_q <= (in_beat.valid && in_ready) ? in_beat : '0;
        end else begin
          e0_q <= (in_beat.valid && in_ready) ? in_beat : '0;
        end
      end else if (in_beat.valid && in_ready) begin
        e1_q <= in_beat;
      end
    end
  end

endmodule : fict_skid

//--- verilog/fict_core.sv
// fifo, checksum coprocessor, event flags and timer
`timescale 1ns/1ns
`include "fict_consts.svh"

module fict_core
  import fict_pkg::*;
#(
  parameter int DEPTH = `FICT_FIFO_DEPTH,
  parameter int AW    = `FICT_FIFO_AW
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        host_wr,
  input  wire fict_byte_t  host_wr_data,
  output logic             host_wr_ready,
  input  wire logic        host_rd,
  output fict_byte_t       queue_data_port,
  output logic             host_rd_valid,
  input  wire logic        host_rd_ready,
  input  wire logic        queue_clear,
  output logic [6:0]       queue_fill_count,
  output logic             queue_overrun_error,
  input  wire logic [5:0]  watermark_value,
  output logic             near_full_flag,
  output logic             near_empty_flag,
  input  wire logic [1:0]  checksum_seed_select,
  input  wire logic        high_bit_leading,
  input  wire logic        checksum_start,
  output fict_byte_t       checksum_result_hi,
  output fict_byte_t       checksum_result_lo,
  output logic             checksum_ready,
  input  wire logic        tx_eof_start,
  input  wire logic        rx_end,
  input  wire logic        command_idle,
  input  wire logic [6:0]  link_error_bits,
  input  wire logic [7:0]  event_enable_register,
  input  wire logic [7:0]  event_flag_set,
  input  wire logic [7:0]  event_flag_clear,
  output logic [7:0]       event_flag_register,
  output logic             irq_status,
  output logic             irq_pin,
  input  wire logic        timer_tick_pin,
  input  wire logic [11:0] timer_divider,
  input  wire logic [15:0] timer_reload_register,
  input  wire logic        timer_auto_reload,
  input  wire logic        timer_start,
  input  wire logic        timer_stop,
  output logic [15:0]      timer_current_value,
  output logic             timer_active
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b, input logic msb);
    logic fb;
    fb      = (msb ? c[15] : c[0]) ^ b;
    crc_bit = (msb ? {c[14:0], 1'b0} : {1'b0, c[15:1]}) ^ (fb ? (msb ? `FICT_CRC_POLY : `FICT_CRC_RPOLY) : 16'h0000);
  endfunction : crc_bit

  function automatic logic [15:0] seed_of(input logic [1:0] s);
    unique case (s)
      2'b00: seed_of = `FICT_SEED_0;
      2'b01: seed_of = `FICT_SEED_1;
      2'b10: seed_of = `FICT_SEED_2;
      2'b11: seed_of = `FICT_SEED_3;
    endcase
  endfunction : seed_of

  // ----------------------------------------
  // fifo pointers
  // ----------------------------------------
  logic [AW:0]   wp_q;
  logic [AW:0]   rp_q;
  logic [AW:0]   level;
  logic          full;
  logic          empty;
  logic          pop;
  logic          crc_pop;
  logic          host_pop;
  logic          rd_pend_q;
  logic          crc_pend_q;
  fict_byte_t    mem_rd;
  fict_beat_s    skid_in;
  logic          skid_in_ready;
  fict_beat_s    skid_out;

  assign level    = wp_q - rp_q;
  assign full     = (level == (AW+1)'(DEPTH));
  assign empty    = (level == '0);
  assign queue_fill_count = 7'(level);
  assign host_wr_ready = 1'b1;
  // one pop in flight at a time; host read blocked while buffer is busy
  assign host_pop = host_rd && !empty && !rd_pend_q && !crc_pend_q && skid_in_ready && !skid_out.valid && !crc_pop;
  assign pop      = host_pop || crc_pop;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wp_q <= '0;
    end else if (clk_en) begin
      if (queue_clear) begin
        wp_q <= '0;
      end else if (host_wr && !full) begin
        wp_q <= wp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rp_q <= '0;
    end else if (clk_en) begin
      if (queue_clear) begin
        rp_q <= '0;
      end else if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      queue_overrun_error <= 1'b0;
    end else if (clk_en) begin
      if (host_wr && full && !queue_clear) begin
        queue_overrun_error <= 1'b1;
      end else if (queue_clear) begin
        queue_overrun_error <= 1'b0;
      end
    end
  end

  fict_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .wr_en   (host_wr && !full && !queue_clear),
    .wr_addr (wp_q[AW-1:0]),
    .wr_data (host_wr_data),
    .rd_addr (rp_q[AW-1:0]),
    .rd_data (mem_rd)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_pend_q  <= 1'b0;
      crc_pend_q <= 1'b0;
    end else if (clk_en) begin
      rd_pend_q  <= host_pop && !queue_clear;
      crc_pend_q <= crc_pop && !queue_clear;
    end
  end

  assign skid_in.valid = rd_pend_q;
  assign skid_in.data  = mem_rd;

  fict_skid u_skid (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n && !(clk_en && queue_clear)),
    .clk_en    (clk_en),
    .in_beat   (skid_in),
    .in_ready  (skid_in_ready),
    .out_beat  (skid_out),
    .out_ready (host_rd_ready)
  );

  assign host_rd_valid   = skid_out.valid;
  assign queue_data_port = skid_out.data;

  // ----------------------------------------
  // watermark alerts
  // ----------------------------------------
  logic [AW:0] space;
  logic        nf_q;
  logic        ne_q;

  assign space           = (AW+1)'(DEPTH) - level;
  assign near_full_flag  = (space <= {1'b0, watermark_value});
  assign near_empty_flag = (level <= {1'b0, watermark_value});

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nf_q <= 1'b0;
      ne_q <= 1'b1;
    end else if (clk_en) begin
      nf_q <= near_full_flag;
      ne_q <= near_empty_flag;
    end
  end

  // ----------------------------------------
  // checksum coprocessor
  // ----------------------------------------
  fict_crc_state_e crc_st_q;
  logic [15:0]     crc_q;
  fict_byte_t      crc_sh_q;
  logic [2:0]      crc_bit_q;
  logic            crc_done;

  assign crc_pop = (crc_st_q == FICT_CRC_LOAD) && !empty && !crc_pend_q && !rd_pend_q;
  assign crc_done = (crc_st_q == FICT_CRC_LOAD) && empty && !crc_pend_q;
  assign checksum_result_hi = crc_q[15:8];
  assign checksum_result_lo = crc_q[7:0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      crc_st_q  <= FICT_CRC_IDLE;
      crc_q     <= '0;
      crc_sh_q  <= '0;
      crc_bit_q <= '0;
    end else if (clk_en) begin
      unique case (crc_st_q)
        FICT_CRC_IDLE: begin
          if (checksum_start) begin
            crc_q    <= seed_of(checksum_seed_select);
            crc_st_q <= FICT_CRC_LOAD;
          end
        end
        FICT_CRC_LOAD: begin
          if (crc_pend_q) begin
            crc_sh_q  <= mem_rd;
            crc_bit_q <= '0;
            crc_st_q  <= FICT_CRC_CALC;
          end else if (crc_done) begin
            crc_st_q <= FICT_CRC_IDLE;
          end
        end
        FICT_CRC_CALC: begin
          crc_q <= crc_bit(crc_q, high_bit_leading ? crc_sh_q[7] : crc_sh_q[0], high_bit_leading);
          crc_sh_q <= high_bit_leading ? {crc_sh_q[6:0], 1'b0} : {1'b0, crc_sh_q[7:1]};
          crc_bit_q <= crc_bit_q + 1'b1;
          if (crc_bit_q == 3'h7) begin
            crc_st_q <= FICT_CRC_LOAD;
          end
        end
        default: crc_st_q <= FICT_CRC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      checksum_ready <= 1'b0;
    end else if (clk_en) begin
      if (crc_done) begin
        checksum_ready <= 1'b1;
      end else if (checksum_start) begin
        checksum_ready <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // timer
  // ----------------------------------------
  logic [2:0]  tick_sync_q;
  logic        tick_stable_q;
  logic        tick_rise;
  logic [11:0] pre_q;
  logic        timer_hit;

  assign tick_rise = (tick_sync_q[1] == tick_sync_q[2]) && tick_sync_q[1] && !tick_stable_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_sync_q   <= '0;
      tick_stable_q <= 1'b0;
    end else if (clk_en) begin
      tick_sync_q <= {tick_sync_q[1:0], timer_tick_pin};
      if (tick_sync_q[1] == tick_sync_q[2]) begin
        tick_stable_q <= tick_sync_q[1];
      end
    end
  end

  assign timer_hit = timer_active && tick_rise && (pre_q == '0) && (timer_current_value == 16'h0001);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pre_q               <= '0;
      timer_current_value <= '0;
      timer_active        <= 1'b0;
    end else if (clk_en) begin
      if (timer_stop) begin
        timer_active <= 1'b0;
      end else if (timer_start) begin
        timer_active        <= 1'b1;
        pre_q               <= timer_divider;
        timer_current_value <= timer_reload_register;
      end else if (timer_active && tick_rise) begin
        if (pre_q != '0) begin
          pre_q <= pre_q - 1'b1;
        end else begin
          pre_q <= timer_divider;
          if (timer_current_value == '0) begin
            if (timer_auto_reload) begin
              timer_current_value <= timer_reload_register;
            end else begin
              timer_active <= 1'b0;
            end
          end else begin
            timer_current_value <= timer_current_value - 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // event flags and irq
  // ----------------------------------------
  logic [7:0] ev_set;

  always_comb begin
    ev_set = event_flag_set;
    ev_set[`FICT_EV_TIMER]      = event_flag_set[`FICT_EV_TIMER] | timer_hit;
    ev_set[`FICT_EV_ERROR]      = event_flag_set[`FICT_EV_ERROR] | (|{link_error_bits, queue_overrun_error});
    ev_set[`FICT_EV_NEAR_EMPTY] = event_flag_set[`FICT_EV_NEAR_EMPTY] | (near_empty_flag && !ne_q);
    ev_set[`FICT_EV_NEAR_FULL]  = event_flag_set[`FICT_EV_NEAR_FULL] | (near_full_flag && !nf_q);
    ev_set[`FICT_EV_IDLE]       = event_flag_set[`FICT_EV_IDLE] | command_idle;
    ev_set[`FICT_EV_RX]         = event_flag_set[`FICT_EV_RX] | rx_end;
    ev_set[`FICT_EV_TX]         = event_flag_set[`FICT_EV_TX] | tx_eof_start;
    ev_set[`FICT_EV_CRC]        = event_flag_set[`FICT_EV_CRC] | crc_done;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      event_flag_register <= '0;
    end else if (clk_en) begin
      event_flag_register <= (event_flag_register & ~event_flag_clear) | ev_set;
    end
  end

  assign irq_status = |(event_flag_register & event_enable_register);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_pin <= 1'b0;
    end else if (clk_en) begin
      irq_pin <= |(event_flag_register & event_enable_register);
    end
  end

endmodule : fict_core

//--- bench/fict_core_asserts.sv
// assertions on the ports of the fifo, checksum, event and timer core
`timescale 1ns/1ns
module fict_core_asserts
  import fict_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       host_wr,
  input wire logic       queue_clear,
  input wire logic [6:0] queue_fill_count,
  input wire logic       queue_overrun_error,
  input wire logic [5:0] watermark_value,
  input wire logic       near_full_flag,
  input wire logic       near_empty_flag,
  input wire logic       checksum_ready,
  input wire logic [6:0] link_error_bits,
  input wire logic [7:0] event_enable_register,
  input wire logic [7:0] event_flag_register,
  input wire logic       irq_status,
  input wire logic       irq_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // fifo
  // ----
  property p_near_full; near_full_flag == (7'h40 - queue_fill_count <= {1'b0, watermark_value}); endproperty
  a_near_full: assert property (p_near_full) else $error("near full flag wrong");
  property p_near_empty; near_empty_flag == (queue_fill_count <= {1'b0, watermark_value}); endproperty
  a_near_empty: assert property (p_near_empty) else $error("near empty flag wrong");
  property p_clear; clk_en && queue_clear && !host_wr |=> queue_fill_count == 7'h00 && !queue_overrun_error; endproperty
  a_clear: assert property (p_clear) else $error("clear left data or overrun");
  property p_overrun; clk_en && host_wr && !queue_clear && queue_fill_count == 7'h40 |=> queue_overrun_error; endproperty
  a_overrun: assert property (p_overrun) else $error("write into full queue not flagged");
  property p_hold; $fell(queue_overrun_error) |-> $past(queue_clear); endproperty
  a_hold: assert property (p_hold) else $error("overrun cleared without clear");
  // ----
  // events
  // ----
  property p_irq_stat; irq_status == |(event_flag_register & event_enable_register); endproperty
  a_irq_stat: assert property (p_irq_stat) else $error("irq status not enabled flags");
  property p_irq_pin; clk_en |=> irq_pin == $past(irq_status); endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin does not follow status");
  property p_alert_ev; $rose(near_full_flag) |-> ##[1:2] event_flag_register[3]; endproperty
  a_alert_ev: assert property (p_alert_ev) else $error("near full event missing");
  property p_link_err; clk_en && link_error_bits != 7'h00 |-> ##[1:2] event_flag_register[1]; endproperty
  a_link_err: assert property (p_link_err) else $error("error event missing");
  property p_crc_done; $rose(checksum_ready) |-> ##[0:1] event_flag_register[7]; endproperty
  a_crc_done: assert property (p_crc_done) else $error("checksum event missing");
  c_overrun: cover property (queue_overrun_error);
  c_full: cover property ($rose(near_full_flag));
  c_crc: cover property ($rose(checksum_ready));
endmodule : fict_core_asserts

//--- bench/fict_host_model.sv
// host-side reader of the queue with random stalls
`timescale 1ns/1ns
module fict_host_model
  import fict_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic slow,
  output logic      host_rd_ready
);
  int seed = 74;
  initial host_rd_ready = 1'b1;
  // ready always, or at random while slow
  always @(negedge sys_clk)
    host_rd_ready <= !slow || $random(seed) % 2 == 0;
endmodule : fict_host_model

//--- bench/test_fict_core.sv
// self-checking bench for the fifo, checksum, event and timer core
`timescale 1ns/1ns
module test_fict_core;
  import fict_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, slow = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
  logic        queue_clear = 1'b0, checksum_start = 1'b0, high_bit_leading = 1'b0, tx_eof_start = 1'b0;
  logic        rx_end = 1'b0, command_idle = 1'b0, timer_tick_pin = 1'b0, timer_auto_reload = 1'b0;
  logic        timer_start = 1'b0, timer_stop = 1'b0;
  logic [1:0]  checksum_seed_select = 2'h0;
  logic [5:0]  watermark_value = 6'h00;
  logic [6:0]  link_error_bits = 7'h00, queue_fill_count;
  logic [7:0]  event_enable_register = 8'h00, event_flag_set = 8'h00, event_flag_clear = 8'h00;
  logic [7:0]  event_flag_register;
  logic [11:0] timer_divider = 12'h000;
  logic [15:0] timer_reload_register = 16'h0003, timer_current_value, crc;
  fict_byte_t  host_wr_data = 8'h00, queue_data_port, checksum_result_hi, checksum_result_lo;
  logic        host_wr_ready, host_rd_valid, host_rd_ready, queue_overrun_error, near_full_flag;
  logic        near_empty_flag, checksum_ready, irq_status, irq_pin, timer_active;
  logic [15:0] seeds [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
  fict_byte_t  exp_q [$];
  int          seed = 74, num_errors = 0, checks_done = 0;

  fict_core u_fict_core (.*);
  fict_host_model u_fict_host_model (.sys_clk(sys_clk), .slow(slow), .host_rd_ready(host_rd_ready));

  always #5 sys_clk = ~sys_clk;
  always #37 timer_tick_pin = ~timer_tick_pin;
  // ----
  // helpers
  // ----
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic flush;
    queue_clear = 1'b1;
    @(negedge sys_clk);
    queue_clear = 1'b0;
  endtask : flush

  task automatic clear_flags;
    event_flag_clear = 8'hFF;
    @(negedge sys_clk);
    event_flag_clear = 8'h00;
  endtask : clear_flags

  task automatic pop;
    int n;
    n = exp_q.size();
    host_rd = 1'b1;
    @(negedge sys_clk);
    host_rd = 1'b0;
    for (int i = 0; i < 40 && exp_q.size() == n; i++)
      @(negedge sys_clk);
    chk("reads left", 16'(n - 1), 16'(exp_q.size()));
  endtask : pop

  function automatic logic [15:0] crc_step(input logic [15:0] c, input fict_byte_t b, input logic msb);
    for (int i = 0; i < 8; i++)
      if (msb)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[7 - i]) ? 16'h1021 : 16'h0000);
      else
        c = {1'b0, c[15:1]} ^ ((c[0] ^ b[i]) ? 16'h8408 : 16'h0000);
    return c;
  endfunction : crc_step

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // ----
  // read monitor
  // ----
  always @(posedge sys_clk)
    if (host_rd_valid === 1'b1 && host_rd_ready === 1'b1) begin
      chk("read data", 16'(exp_q[0]), 16'(queue_data_port));
      void'(exp_q.pop_front());
    end

  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk("fill count", 16'h0000, queue_fill_count);
    chk("near empty", 16'h0001, near_empty_flag);
    chk("event flags", 16'h0000, event_flag_register);
    chk("write ready", 16'h0001, host_wr_ready);
    $display("reset test done");
    watermark_value = 6'($random(seed));
    event_enable_register = 8'h08;
    host_wr = 1'b1;
    for (int i = 1; i <= 64; i++) begin
      host_wr_data = 8'($random(seed));
      exp_q.push_back(host_wr_data);
      @(negedge sys_clk);
      chk("fill count", 16'(i), queue_fill_count);
      chk("near full", 16'(64 - i <= watermark_value), near_full_flag);
      chk("near empty", 16'(i <= watermark_value), near_empty_flag);
    end
    @(negedge sys_clk);
    host_wr = 1'b0;
    cyc(3);
    chk("overrun", 16'h0001, queue_overrun_error);
    chk("fill count", 16'h0040, queue_fill_count);
    chk("irq pin", 16'h0001, irq_pin);
    slow = 1'b1;
    repeat (64) pop();
    slow = 1'b0;
    chk("overrun", 16'h0001, queue_overrun_error);
    flush();
    chk("overrun", 16'h0000, queue_overrun_error);
    host_wr = 1'b1;
    cyc(5);
    host_wr = 1'b0;
    flush();
    chk("fill count", 16'h0000, queue_fill_count);
    clk_en = 1'b0;
    host_wr = 1'b1;
    cyc(3);
    host_wr = 1'b0;
    clk_en = 1'b1;
    chk("frozen fill", 16'h0000, queue_fill_count);
    host_wr_data = 8'h3C;
    exp_q.push_back(8'h3C);
    host_wr = 1'b1;
    @(negedge sys_clk);
    host_wr = 1'b0;
    pop();
    $display("queue test done");
    for (int m = 0; m < 8; m++) begin
      checksum_seed_select = 2'(m);
      high_bit_leading = m[2];
      crc = seeds[m[1:0]];
      host_wr = 1'b1;
      repeat (3) begin
        host_wr_data = 8'($random(seed));
        crc = crc_step(crc, host_wr_data, m[2]);
        @(negedge sys_clk);
      end
      host_wr = 1'b0;
      event_flag_clear = 8'h80;
      checksum_start = 1'b1;
      @(negedge sys_clk);
      event_flag_clear = 8'h00;
      checksum_start = 1'b0;
      for (int j = 0; j < 300 && event_flag_register[7] !== 1'b1; j++)
        @(negedge sys_clk);
      chk("crc high", 16'(crc[15:8]), 16'(checksum_result_hi));
      chk("crc low", 16'(crc[7:0]), 16'(checksum_result_lo));
      chk("crc ready", 16'h0001, checksum_ready);
    end
    $display("checksum test done");
    event_enable_register = 8'h70;
    clear_flags();
    for (int b = 4; b < 8; b++) begin
      command_idle = b == 4;
      rx_end = b == 5;
      tx_eof_start = b == 6;
      link_error_bits = b == 7 ? 7'($random(seed)) | 7'h01 : 7'h00;
      @(negedge sys_clk);
      {command_idle, rx_end, tx_eof_start} = 3'b000;
      link_error_bits = 7'h00;
      cyc(3);
      chk("event flags", b == 7 ? 16'h0002 : 16'h0001 << b, event_flag_register);
      chk("irq pin", 16'(b < 7), irq_pin);
      clear_flags();
    end
    event_flag_set = 8'h01;
    @(negedge sys_clk);
    event_flag_set = 8'h00;
    chk("host set flag", 16'h0001, event_flag_register);
    chk("masked irq", 16'h0000, irq_status);
    clear_flags();
    chk("host clear flag", 16'h0000, event_flag_register);
    $display("event test done");
    for (int a = 0; a < 2; a++) begin
      timer_auto_reload = a[0];
      timer_divider = 12'(a);
      timer_start = 1'b1;
      @(negedge sys_clk);
      timer_start = 1'b0;
      chk("timer value", timer_reload_register, timer_current_value);
      for (int j = 0; j < 3000 && event_flag_register[0] !== 1'b1; j++)
        @(negedge sys_clk);
      cyc(20);
      chk("timer flag", 16'h0001, event_flag_register[0]);
      chk("timer active", 16'(a), timer_active);
      timer_stop = 1'b1;
      @(negedge sys_clk);
      timer_stop = 1'b0;
      clear_flags();
    end
    $display("timer test done");
    end_of_test();
  end
endmodule : test_fict_core

bind fict_core fict_core_asserts u_fict_core_asserts (.*);
